// *** include/exec_pkg.sv ***
// constants, types and register map for the compare/adjust/decrement execution block
package exec_pkg;
    // ****************************************
    // apb register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_ACC = 8'h00;
    localparam logic [7:0] ADDR_BANK_PTR = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_EXEC_STATE = 8'h0C;
    localparam logic [7:0] RESET_ACC = 8'h00;
    localparam logic [3:0] RESET_BANK_PTR = 4'h0;
    localparam logic [4:0] RESET_STATUS = 5'h00;

    // ****************************************
    // status flag bit positions
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_NIBBLE_CARRY = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_RANGE_ERR = 3;
    localparam int FLAG_N = 4;

    // ****************************************
    // instruction encodings
    // ****************************************
    localparam logic [3:0] CMP_TOP = 4'h6;
    localparam logic [2:0] CMP_LOW_ZERO = 3'h0;
    localparam logic [15:0] BCD_ADJ_WORD = 16'h0007;
    localparam logic [5:0] DEC_TOP = 6'h01;
    localparam int DEC_DEST_BIT = 9;
    localparam int DEC_BANK_BIT = 8;
    localparam int CMP_BANK_BIT = 0;

    // ****************************************
    // access bank split and arithmetic constants
    // ****************************************
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LO_ADJ = 9'h006;
    localparam logic [8:0] BCD_HI_ADJ = 9'h060;
    localparam logic [7:0] RANGE_ERR_VAL = 8'h80;
    localparam logic [1:0] SKIP_ONE = 2'h1;
    localparam logic [1:0] SKIP_TWO = 2'h2;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_CMP = 3'b001,
        OP_BCD = 3'b010,
        OP_DEC = 3'b011,
        OP_FLUSH = 3'b100
    } op_t;
endpackage

// *** hw/q_phase_counter.sv ***
// four-phase instruction cycle sequencer
module q_phase_counter (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    output exec_pkg::phase_t phase
);
    import exec_pkg::*;

    phase_t phase_q;
    phase_t phase_d;

    always_comb begin
        phase_d = phase_t'(phase_q + 2'b01);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= PH_Q1;
        end else if (ce) begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;
endmodule

// *** hw/compare_skip_bcd_decrement_exec.sv ***
// execution unit for compare-skip-if-less, bcd accumulator adjust and file decrement
// Contract
// - compare is unsigned, flags stay untouched
// - file less than accumulator flushes next instruction
// - one cycle, two on skip, three over two-word
// - bank bit zero forces access bank
// - compare word: top 0110, address, bank bit
// - compare phases: decode, read, process, idle
// - bcd adjust adds six per nibble, carry only
module compare_skip_bcd_decrement_exec (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [15:0] instr_word,
    input wire logic next_two_word,
    input wire logic [7:0] fr_rd_data,
    output logic [11:0] fr_addr,
    output logic fr_wr_en,
    output logic [7:0] fr_wr_data,
    output logic instr_taken,
    output logic instr_flushed,
    output exec_pkg::phase_t q_phase
);
    import exec_pkg::*;

    phase_t phase;
    op_t op_q, op_d;
    logic [7:0] acc_q, acc_d;
    logic [3:0] bank_ptr_q, bank_ptr_d;
    logic [4:0] flags_q, flags_d;
    logic [7:0] operand_q, operand_d;
    logic [7:0] result_q, result_d;
    logic dest_file_q, dest_file_d;
    logic two_word_q, two_word_d;
    logic [1:0] skip_q, skip_d;
    logic [11:0] fr_addr_q, fr_addr_d;
    logic fr_wr_en_q, fr_wr_en_d;
    logic taken_q, taken_d;
    logic flushed_q, flushed_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;

    logic [8:0] bcd_sum;
    logic bank_bit;
    logic [7:0] file_field;

    q_phase_counter u_phase (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .phase(phase)
    );

    // ****************************************
    // instruction sequencing and datapath
    // ****************************************
    always_comb begin
        op_d = op_q;
        acc_d = acc_q;
        flags_d = flags_q;
        operand_d = operand_q;
        result_d = result_q;
        dest_file_d = dest_file_q;
        two_word_d = two_word_q;
        skip_d = skip_q;
        fr_addr_d = fr_addr_q;
        fr_wr_en_d = 1'b0;
        taken_d = 1'b0;
        flushed_d = 1'b0;
        bcd_sum = 9'h000;
        bank_bit = 1'b1;
        file_field = 8'h00;
        case (phase)
            PH_Q1: begin
                if (skip_q != 2'b00) begin
                    // the fetched word is dropped; this cycle is four idle phases
                    op_d = OP_FLUSH;
                    flushed_d = 1'b1;
                end else if (instr_word[15:12] == CMP_TOP
                             && instr_word[3:1] == CMP_LOW_ZERO) begin
                    op_d = OP_CMP;
                    file_field = instr_word[11:4];
                    bank_bit = instr_word[CMP_BANK_BIT];
                    two_word_d = next_two_word;
                    taken_d = 1'b1;
                end else if (instr_word == BCD_ADJ_WORD) begin
                    op_d = OP_BCD;
                    taken_d = 1'b1;
                end else if (instr_word[15:10] == DEC_TOP) begin
                    op_d = OP_DEC;
                    file_field = instr_word[7:0];
                    bank_bit = instr_word[DEC_BANK_BIT];
                    dest_file_d = instr_word[DEC_DEST_BIT];
                    taken_d = 1'b1;
                end else begin
                    op_d = OP_NONE;
                end
                if (bank_bit) begin
                    fr_addr_d = {bank_ptr_q, file_field};
                end else if (file_field < ACCESS_SPLIT) begin
                    fr_addr_d = {ACCESS_LOW_BANK, file_field};
                end else begin
                    fr_addr_d = {ACCESS_HIGH_BANK, file_field};
                end
            end
            PH_Q2: begin
                if (op_q == OP_BCD) begin
                    operand_d = acc_q;
                end else begin
                    operand_d = fr_rd_data;
                end
            end
            PH_Q3: begin
                case (op_q)
                    OP_CMP: begin
                        // unsigned; status is deliberately not written
                        if (operand_q < acc_q) begin
                            skip_d = two_word_q ? SKIP_TWO : SKIP_ONE;
                        end
                    end
                    OP_BCD: begin
                        bcd_sum = {1'b0, acc_q};
                        if (acc_q[3:0] > BCD_MAX || flags_q[FLAG_NIBBLE_CARRY]) begin
                            bcd_sum = bcd_sum + BCD_LO_ADJ;
                        end
                        if (acc_q[7:4] > BCD_MAX || flags_q[FLAG_C]) begin
                            bcd_sum = bcd_sum + BCD_HI_ADJ;
                        end
                        result_d = bcd_sum[7:0];
                        flags_d[FLAG_C] = flags_q[FLAG_C] | bcd_sum[8];
                    end
                    OP_DEC: begin
                        result_d = operand_q - 8'h01;
                        // carry and nibble carry read as "no borrow"
                        flags_d[FLAG_C] = (operand_q != 8'h00);
                        flags_d[FLAG_NIBBLE_CARRY] = (operand_q[3:0] != 4'h0);
                        flags_d[FLAG_Z] = (operand_q == 8'h01);
                        flags_d[FLAG_RANGE_ERR] = (operand_q == RANGE_ERR_VAL);
                        flags_d[FLAG_N] = result_d[7];
                    end
                    default: begin
                    end
                endcase
            end
            PH_Q4: begin
                case (op_q)
                    OP_BCD: begin
                        acc_d = result_q;
                    end
                    OP_DEC: begin
                        if (dest_file_q) begin
                            fr_wr_en_d = 1'b1;
                        end else begin
                            acc_d = result_q;
                        end
                    end
                    OP_FLUSH: begin
                        skip_d = skip_q - 2'b01;
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
            end
        endcase
    end

    // ****************************************
    // apb slave; zero wait states, answer registered in setup
    // ****************************************
    always_comb begin
        bank_ptr_d = bank_ptr_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (psel && !penable) begin
            pready_d = 1'b1;
            case (paddr)
                ADDR_ACC: prdata_d = {24'h00_0000, acc_q};
                ADDR_BANK_PTR: prdata_d = {28'h000_0000, bank_ptr_q};
                ADDR_STATUS: prdata_d = {27'h000_0000, flags_q};
                ADDR_EXEC_STATE: prdata_d = {24'h00_0000, skip_q, op_q, 1'b0, phase};
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            op_q <= OP_NONE;
            acc_q <= RESET_ACC;
            bank_ptr_q <= RESET_BANK_PTR;
            flags_q <= RESET_STATUS;
            operand_q <= 8'h00;
            result_q <= 8'h00;
            dest_file_q <= 1'b0;
            two_word_q <= 1'b0;
            skip_q <= 2'b00;
            fr_addr_q <= 12'h000;
            fr_wr_en_q <= 1'b0;
            taken_q <= 1'b0;
            flushed_q <= 1'b0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            op_q <= op_d;
            operand_q <= operand_d;
            result_q <= result_d;
            dest_file_q <= dest_file_d;
            two_word_q <= two_word_d;
            skip_q <= skip_d;
            fr_addr_q <= fr_addr_d;
            fr_wr_en_q <= fr_wr_en_d;
            taken_q <= taken_d;
            flushed_q <= flushed_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            // software write lands after the core update, so it wins a same-edge clash
            if (psel && penable && pready_q && pwrite && !pslverr_q) begin
                acc_q <= (paddr == ADDR_ACC) ? pwdata[7:0] : acc_d;
                bank_ptr_q <= (paddr == ADDR_BANK_PTR) ? pwdata[3:0] : bank_ptr_d;
                flags_q <= (paddr == ADDR_STATUS) ? pwdata[4:0] : flags_d;
            end else begin
                acc_q <= acc_d;
                bank_ptr_q <= bank_ptr_d;
                flags_q <= flags_d;
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign fr_addr = fr_addr_q;
    assign fr_wr_en = fr_wr_en_q;
    assign fr_wr_data = result_q;
    assign instr_taken = taken_q;
    assign instr_flushed = flushed_q;
    assign q_phase = phase;
endmodule

// *** sim/exec_monitor.sv ***
// port-level assertion checker for the execution block
module exec_monitor
    import exec_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] fr_rd_data,
    input wire logic [11:0] fr_addr,
    input wire logic fr_wr_en,
    input wire logic [7:0] fr_wr_data,
    input wire logic instr_taken,
    input wire logic instr_flushed,
    input wire exec_pkg::phase_t q_phase
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic cmp_q1;
    logic dec_q1;
    logic bcd_q1;
    logic q1_run;
    assign q1_run = q_phase == PH_Q1 && ce;
    assign cmp_q1 = q1_run && instr_word[15:12] == CMP_TOP && instr_word[3:1] == CMP_LOW_ZERO;
    assign dec_q1 = q1_run && instr_word[15:10] == DEC_TOP;
    assign bcd_q1 = q1_run && instr_word == BCD_ADJ_WORD;

    phase_step_a: assert property (ce |=> q_phase == $past(q_phase) + 2'h1)
        else $error("phase did not advance");
    phase_hold_a: assert property (!ce |=> q_phase == $past(q_phase))
        else $error("phase moved while frozen");
    // a word seen during a skip cycle is ignored, so only decoded words are judged
    cmp_addr_a: assert property (cmp_q1 ##1 !instr_flushed |->
        fr_addr[7:0] == $past(instr_word[11:4])
        && ($past(instr_word[0]) || fr_addr[11:8] ==
        ($past(instr_word[11]) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK)))
        else $error("compare address wrong");
    cmp_quiet_a: assert property (cmp_q1 |=> !fr_wr_en [*4])
        else $error("compare wrote a register");
    bcd_quiet_a: assert property (bcd_q1 |=> !fr_wr_en [*4])
        else $error("adjust wrote a register");
    dec_dest_a: assert property (dec_q1 ##1 !instr_flushed |-> ##3
        fr_wr_en == $past(instr_word[9], 4))
        else $error("decrement destination wrong");
    wr_phase_a: assert property (fr_wr_en |-> q_phase == PH_Q1 && !instr_flushed)
        else $error("write outside its slot");
    wr_data_a: assert property (fr_wr_en |-> fr_wr_data == 8'($past(fr_rd_data, 3) - 8'h01))
        else $error("decrement data wrong");
    flush_cause_a: assert property (instr_flushed |-> $past(instr_taken, 4)
        || $past(instr_flushed, 4))
        else $error("flush without compare");
    flush_limit_a: assert property (instr_flushed && $past(instr_flushed, 4)
        |-> ##4 !instr_flushed)
        else $error("more than two flush cycles");
    flush_phase_a: assert property (instr_flushed |-> q_phase == PH_Q2 && !instr_taken)
        else $error("flush pulse misplaced");
endmodule

bind compare_skip_bcd_decrement_exec exec_monitor exec_monitor_inst (
    .mclk, .rst_b, .ce, .instr_word, .fr_rd_data, .fr_addr, .fr_wr_en, .fr_wr_data,
    .instr_taken, .instr_flushed, .q_phase);

// *** sim/tb_top.sv ***
// self-checking bench for the execution block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;
    logic mclk, rst_b, ce, psel, penable, pwrite, next_two_word, pready, pslverr;
    logic fr_wr_en, instr_taken, instr_flushed, err, took;
    logic [7:0] paddr, fr_rd_data, fr_wr_data, got_wr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] instr_word;
    logic [11:0] fr_addr, got_addr;
    phase_t q_phase;
    int fail_count, checked, nflush, nwr, wr_at;

    compare_skip_bcd_decrement_exec compare_skip_bcd_decrement_exec_inst (
        .mclk, .rst_b, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
        .pslverr, .instr_word, .next_two_word, .fr_rd_data, .fr_addr, .fr_wr_en,
        .fr_wr_data, .instr_taken, .instr_flushed, .q_phase);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        fail_count++;
        $display("[FAIL] wait bound used up");
        complete_run();
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) timed_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // word goes in for exactly one Q1; outputs watched for three instruction cycles
    task automatic exec(input logic [15:0] w, input logic [7:0] fd, input logic two);
        @(negedge mclk);
        for (int i = 0; i < 8 && q_phase !== PH_Q4; i++) @(negedge mclk);
        if (q_phase !== PH_Q4) timed_out();
        @(posedge mclk);
        instr_word <= w;
        fr_rd_data <= fd;
        next_two_word <= two;
        @(posedge mclk);
        instr_word <= 16'h0000;
        nflush = 0;
        nwr = 0;
        wr_at = 0;
        @(negedge mclk);
        took = instr_taken;
        got_addr = fr_addr;
        for (int i = 2; i <= 12; i++) begin
            @(negedge mclk);
            if (fr_wr_en === 1'b1) begin
                nwr++;
                wr_at = i;
                got_wr = fr_wr_data;
            end
            if (instr_flushed === 1'b1) nflush++;
        end
        chk("taken", 32'h1, {31'h0, took});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        apb(ADDR_ACC, 1'b0, '0);
        chk("acc reset", {24'h0, RESET_ACC}, rd);
        apb(ADDR_STATUS, 1'b0, '0);
        chk("status reset", {27'h0, RESET_STATUS}, rd);
        apb(ADDR_BANK_PTR, 1'b1, 32'hFFFFFFF3);
        apb(ADDR_BANK_PTR, 1'b0, '0);
        chk("bank ptr", 32'h3, rd);
        apb(8'h10, 1'b0, '0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(ADDR_EXEC_STATE, 1'b0, '0);
        chk("exec state idle", 32'h0, rd & 32'hFFFF_FFFC);
        $display("t_regs done");
    endtask

    // clock enable low must freeze the phase sequencer, then it resumes
    task automatic t_hold();
        phase_t held;
        @(posedge mclk);
        ce <= 1'b0;
        @(negedge mclk);
        held = q_phase;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk("phase frozen", {30'h0, held}, {30'h0, q_phase});
        @(posedge mclk);
        ce <= 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        chk("phase resumed", {30'h0, 2'(held + 2'h1)}, {30'h0, q_phase});
        $display("t_hold done");
    endtask

    task automatic t_cmp();
        apb(ADDR_ACC, 1'b1, 32'h80);
        apb(ADDR_STATUS, 1'b1, 32'h1F);
        exec({CMP_TOP, 8'h12, 4'h1}, 8'h80, 1'b0);
        chk("cmp addr", 32'h312, got_addr);
        chk("equal flush", 32'h0, nflush);
        exec({CMP_TOP, 8'h90, 4'h0}, 8'h7F, 1'b0);
        chk("access addr", 32'hF90, got_addr);
        chk("less flush", 32'h1, nflush);
        exec({CMP_TOP, 8'h10, 4'h0}, 8'h00, 1'b1);
        chk("low addr", 32'h010, got_addr);
        chk("two word flush", 32'h2, nflush);
        chk("cmp writes", 32'h0, nwr);
        apb(ADDR_STATUS, 1'b0, '0);
        chk("cmp flags", 32'h1F, rd);
        $display("t_cmp done");
    endtask

    task automatic t_bcd();
        logic [31:0] tab [3][4] = '{'{32'hA5, 32'h1C, 32'h05, 32'h1D},
            '{32'hCE, 32'h00, 32'h34, 32'h01}, '{32'h12, 32'h02, 32'h18, 32'h02}};
        for (int i = 0; i < 3; i++) begin
            apb(ADDR_ACC, 1'b1, tab[i][0]);
            apb(ADDR_STATUS, 1'b1, tab[i][1]);
            exec(BCD_ADJ_WORD, 8'h00, 1'b0);
            chk("bcd writes", 32'h0, nwr);
            apb(ADDR_ACC, 1'b0, '0);
            chk("bcd acc", tab[i][2], rd);
            apb(ADDR_STATUS, 1'b0, '0);
            chk("bcd flags", tab[i][3], rd);
        end
        $display("t_bcd done");
    endtask

    task automatic t_dec();
        logic [15:0] tab [3][6] = '{
            '{{DEC_TOP, 2'b11, 8'h20}, 16'h01, 16'h320, 16'h1, 16'h00, 16'h07},
            '{{DEC_TOP, 2'b00, 8'h85}, 16'h80, 16'hF85, 16'h0, 16'h7F, 16'h09},
            '{{DEC_TOP, 2'b10, 8'h05}, 16'h00, 16'h005, 16'h1, 16'hFF, 16'h10}};
        for (int i = 0; i < 3; i++) begin
            apb(ADDR_STATUS, 1'b1, 32'h1F);
            exec(tab[i][0], tab[i][1][7:0], 1'b0);
            chk("dec addr", {16'h0, tab[i][2]}, got_addr);
            chk("dec writes", {16'h0, tab[i][3]}, nwr);
            if (tab[i][3] == 16'h1) begin
                chk("dec wr cycle", 32'h4, wr_at);
                chk("dec wr data", {16'h0, tab[i][4]}, got_wr);
            end else begin
                apb(ADDR_ACC, 1'b0, '0);
                chk("dec acc", {16'h0, tab[i][4]}, rd);
            end
            apb(ADDR_STATUS, 1'b0, '0);
            chk("dec flags", {16'h0, tab[i][5]}, rd);
        end
        $display("t_dec done");
    endtask

    initial begin
        {rst_b, psel, penable, pwrite, next_two_word} = '0;
        ce = 1'b1;
        {paddr, pwdata, instr_word, fr_rd_data} = '0;
        fail_count = 0;
        checked = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_hold();
        t_cmp();
        t_bcd();
        t_dec();
        complete_run();
    end
endmodule
